// file: hdl/twm_pkg.sv
// Constants, register map and types for the tape write/read mode control.
// Assumes a 32-bit APB bus on pclk at 125 MHz.
package twm_pkg;
    // ----------------------------------------------------------------
    // Register map (byte offsets)
    // ----------------------------------------------------------------
    localparam logic [7:0] TWM_CTRL_OFS   = 8'h00;
    localparam logic [7:0] TWM_STATUS_OFS = 8'h04;
    localparam logic [7:0] TWM_WDATA_OFS  = 8'h08;
    localparam logic [7:0] TWM_AMPERR_OFS = 8'h0c;

    // ----------------------------------------------------------------
    // Control field positions
    // ----------------------------------------------------------------
    localparam int CTRL_SELECTED = 0;
    localparam int CTRL_READY    = 1;
    localparam int CTRL_ONLINE   = 2;
    localparam int CTRL_WR_CMD   = 3;
    localparam int CTRL_RD_CMD   = 4;
    localparam int CTRL_MOT_CMD  = 5;
    localparam int CTRL_LOAD_CMD = 6;
    localparam int CTRL_GCR      = 7;
    localparam int CTRL_WIDTH    = 8;
    localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 8'h00;

    // ----------------------------------------------------------------
    // Status field positions
    // ----------------------------------------------------------------
    localparam int ST_MOTION    = 0;
    localparam int ST_WRITE_N   = 1;
    localparam int ST_FPROT     = 2;
    localparam int ST_WPOWER    = 3;
    localparam int ST_HOLD      = 4;
    localparam int ST_SERVO_N   = 5;
    localparam int ST_FORMAT_N  = 6;
    localparam int ST_WIDTH     = 7;

    localparam int CHAR_W = 9;
    localparam logic [CHAR_W-1:0] CHAR_ZERO = 9'h000;
    localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

    typedef enum logic [1:0] {TWM_IDLE, TWM_READ, TWM_WRITE} twm_op_t;
endpackage

// file: hdl/twm_amp_check.sv
// Per-track amplitude error flags from read-after-write pointer data.
// Assumes pointer characters arrive with a one-cycle valid on pclk.
`timescale 1ns/100ps
module twm_amp_check (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      clear,
    input  wire logic                      check_en,
    input  wire logic                      exp_valid,
    input  wire logic [twm_pkg::CHAR_W-1:0] exp_char,
    input  wire logic                      ptr_valid,
    input  wire logic [twm_pkg::CHAR_W-1:0] ptr_char,
    output logic      [twm_pkg::CHAR_W-1:0] amp_err
);
    import twm_pkg::*;

    typedef struct packed {
        logic [CHAR_W-1:0] expect_c;
        logic              have;
        logic [CHAR_W-1:0] err;
    } twm_amp_st_t;

    twm_amp_st_t st_r;
    twm_amp_st_t st_nxt;

    // ----------------------------------------------------------------
    // Compare last written character against pointer readback
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        if (exp_valid) begin
            st_nxt.expect_c = exp_char;
            st_nxt.have     = 1'b1;
        end
        // A mismatching one bit means the track lost amplitude
        if (clear) begin
            st_nxt.err  = CHAR_ZERO;
            st_nxt.have = 1'b0;
        end
        // Set wins over clear so no late error is lost
        if (check_en && ptr_valid && st_r.have) begin
            st_nxt.err = st_nxt.err | (st_r.expect_c ^ ptr_char);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign amp_err = st_r.err;
endmodule

// file: hdl/twm_mode_ctrl.sv
// Mode and write-permission control of a nine-track tape drive, APB slave.
// Assumes synchronous APB master on pclk; drive pins are asynchronous.
//
// Behaviour
// - Format select high picks group-coded, low picks phase-encoded.
// - Operation select high means read and low means write.
// - Writing starts only when selected, ready, on line, write and motion.
// - Write conditions drive motion high and operation select low.
// - Read plus motion command drives motion high, operation select high.
// - A load command drives the reel servo enable low.
// - Write power with servo enable low gives file protect low, feedback low.
// - Low lockout feedback energises the hold path; write power follows the ring alone.
// - Without write power file protect is high and the hold stays released.
// - Without a write enable ring write power is never applied.
// - The read channel runs in read and write modes alike.
// - Recovered characters go back to write logic as pointer bits.
// - Per-track amplitude error flags come from the pointer data.
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/100ps
module twm_mode_ctrl (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [7:0]                 paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic                       ring_switch,
    input  wire logic                       host_write_strobe,
    input  wire logic                       host_write_parity,
    input  wire logic [7:0]                 host_write_bit,
    input  wire logic                       test_select_n,
    input  wire logic                       test_strobe_n,
    input  wire logic                       ptr_valid,
    input  wire logic [twm_pkg::CHAR_W-1:0] raw_pointer_bit,
    output logic                            format_select_n,
    output logic                            op_select_write_n,
    output logic                            motion,
    output logic                            reel_servo_enable_n,
    output logic                            file_protect,
    output logic                            lockout_feedback_n,
    output logic                            write_lockout_hold,
    output logic                            write_power,
    output logic                            test_select,
    output logic                            test_strobe,
    output logic                            wr_char_valid,
    output logic      [twm_pkg::CHAR_W-1:0] wr_char,
    output logic      [twm_pkg::CHAR_W-1:0] track_amplitude_error
);
    import twm_pkg::*;

    typedef struct packed {
        logic [CTRL_WIDTH-1:0] ctrl;
        twm_op_t               op;
        logic                  servo_n;
        logic                  hold;
        logic [1:0]            ring_s;
        logic [1:0]            stb_s;
        logic                  stb_d;
        logic [1:0]            tsel_s;
        logic [1:0]            tstb_s;
        logic [CHAR_W-1:0]     hd_s0;
        logic [CHAR_W-1:0]     hd_s1;
        logic [CHAR_W-1:0]     char_q;
        logic                  char_v;
        logic                  clr;
        logic [31:0]           rdata;
    } twm_st_t;

    twm_st_t st_r;
    twm_st_t st_nxt;

    logic              ring_q;
    logic              pwr;
    logic              fprot_n;
    logic              wr_ok;
    logic              rd_ok;
    logic              stb_rise;
    logic              apb_wr;
    logic              apb_rd;
    logic              mapped;
    logic [CHAR_W-1:0] amp_err;
    logic [CHAR_W-1:0] host_char;

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == TWM_CTRL_OFS) || (a == TWM_STATUS_OFS) ||
                    (a == TWM_WDATA_OFS) || (a == TWM_AMPERR_OFS);
    endfunction

    // ----------------------------------------------------------------
    // Write permission path
    // ----------------------------------------------------------------
    assign ring_q  = st_r.ring_s[1];
    // Hold path cannot create power: the ring switch must be closed
    assign pwr     = ring_q;
    // Writable only with power and servo enabled
    assign fprot_n = pwr && !st_r.servo_n;
    assign host_char = {host_write_parity, host_write_bit};

    // ----------------------------------------------------------------
    // Command qualification
    // ----------------------------------------------------------------
    assign wr_ok = st_r.ctrl[CTRL_SELECTED] && st_r.ctrl[CTRL_READY] &&
                   st_r.ctrl[CTRL_ONLINE] && st_r.ctrl[CTRL_WR_CMD] &&
                   st_r.ctrl[CTRL_MOT_CMD];
    assign rd_ok = st_r.ctrl[CTRL_RD_CMD] && st_r.ctrl[CTRL_MOT_CMD];

    assign stb_rise = st_r.stb_s[1] && !st_r.stb_d;
    assign apb_wr   = psel && penable && pwrite;
    // Read data is captured in setup so it stands at the access edge
    assign apb_rd   = psel && !penable && !pwrite;
    assign mapped   = is_mapped(paddr);

    always_comb begin
        st_nxt        = st_r;
        st_nxt.ring_s = {st_r.ring_s[0], ring_switch};
        st_nxt.stb_s  = {st_r.stb_s[0], host_write_strobe};
        st_nxt.stb_d  = st_r.stb_s[1];
        st_nxt.tsel_s = {st_r.tsel_s[0], test_select_n};
        st_nxt.tstb_s = {st_r.tstb_s[0], test_strobe_n};
        // Data pins pass two flops, matching the strobe path
        st_nxt.hd_s0  = host_char;
        st_nxt.hd_s1  = st_r.hd_s0;
        st_nxt.char_v = 1'b0;
        st_nxt.clr    = 1'b0;

        if (apb_wr && paddr == TWM_CTRL_OFS) begin
            st_nxt.ctrl = pwdata[CTRL_WIDTH-1:0];
        end

        // Load command holds servo enable low until cleared
        st_nxt.servo_n = !st_nxt.ctrl[CTRL_LOAD_CMD];

        // Hold path follows low feedback and drops with power
        st_nxt.hold = fprot_n;

        // Write has priority; read-only is write suppressed
        case (st_r.op)
            TWM_IDLE: begin
                if (wr_ok) begin
                    st_nxt.op  = TWM_WRITE;
                    st_nxt.clr = 1'b1;
                end else if (rd_ok) begin
                    st_nxt.op = TWM_READ;
                end
            end
            TWM_WRITE: begin
                if (!wr_ok) begin
                    st_nxt.op = rd_ok ? TWM_READ : TWM_IDLE;
                end
            end
            TWM_READ: begin
                if (wr_ok) begin
                    st_nxt.op  = TWM_WRITE;
                    st_nxt.clr = 1'b1;
                end else if (!rd_ok) begin
                    st_nxt.op = TWM_IDLE;
                end
            end
            default: begin
                st_nxt.op = TWM_IDLE;
            end
        endcase

        // Data bits are settled long before the strobe edge is seen
        if (stb_rise && st_r.op == TWM_WRITE && fprot_n) begin
            st_nxt.char_q = st_r.hd_s1;
            st_nxt.char_v = 1'b1;
        end
        // Software may also feed a character
        if (apb_wr && paddr == TWM_WDATA_OFS &&
            st_r.op == TWM_WRITE && fprot_n) begin
            st_nxt.char_q = pwdata[CHAR_W-1:0];
            st_nxt.char_v = 1'b1;
        end

        if (apb_rd) begin
            case (paddr)
                TWM_CTRL_OFS: begin
                    st_nxt.rdata = {{(32-CTRL_WIDTH){1'b0}}, st_r.ctrl};
                end
                TWM_STATUS_OFS: begin
                    st_nxt.rdata = DATA_ZERO;
                    st_nxt.rdata[ST_MOTION]   = motion;
                    st_nxt.rdata[ST_WRITE_N]  = op_select_write_n;
                    st_nxt.rdata[ST_FPROT]    = file_protect;
                    st_nxt.rdata[ST_WPOWER]   = pwr;
                    st_nxt.rdata[ST_HOLD]     = st_r.hold;
                    st_nxt.rdata[ST_SERVO_N]  = st_r.servo_n;
                    st_nxt.rdata[ST_FORMAT_N] = format_select_n;
                end
                TWM_WDATA_OFS: begin
                    st_nxt.rdata = {{(32-CHAR_W){1'b0}}, st_r.char_q};
                end
                TWM_AMPERR_OFS: begin
                    st_nxt.rdata = {{(32-CHAR_W){1'b0}}, amp_err};
                end
                default: begin
                    st_nxt.rdata = DATA_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r      <= '0;
            st_r.ctrl <= CTRL_RESET;
            st_r.op   <= TWM_IDLE;
            st_r.servo_n <= 1'b1;
            st_r.ring_s  <= 2'h0;
            st_r.tsel_s  <= 2'h3;
            st_r.tstb_s  <= 2'h3;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Read-after-write checking
    // ----------------------------------------------------------------
    // Read channel runs in both modes; checking only while writing
    twm_amp_check u_amp (
        .pclk      (pclk),
        .presetn   (presetn),
        .clear     (st_r.clr),
        .check_en  (st_r.op == TWM_WRITE),
        .exp_valid (st_r.char_v),
        .exp_char  (st_r.char_q),
        .ptr_valid (ptr_valid),
        .ptr_char  (raw_pointer_bit),
        .amp_err   (amp_err)
    );

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // APB: one-cycle access phase, read data registered in setup
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata  = st_r.rdata;

    assign format_select_n     = st_r.ctrl[CTRL_GCR];
    assign op_select_write_n   = (st_r.op != TWM_WRITE);
    assign motion              = (st_r.op != TWM_IDLE);
    assign reel_servo_enable_n = st_r.servo_n;
    assign file_protect        = !fprot_n;
    assign lockout_feedback_n  = !fprot_n;
    assign write_lockout_hold  = st_r.hold;
    assign write_power         = pwr;
    assign test_select         = !st_r.tsel_s[1];
    assign test_strobe         = !st_r.tstb_s[1];
    assign wr_char_valid       = st_r.char_v;
    assign wr_char             = st_r.char_q;
    assign track_amplitude_error = amp_err;
endmodule

// file: verification/twm_mode_ctrl_sva.sv
// Checker for the tape write/read mode control, attached by bind.
// Assumes the port names of twm_mode_ctrl and one pclk domain.
`timescale 1ns/100ps
module twm_mode_ctrl_sva (
    input wire logic                       pclk,
    input wire logic                       presetn,
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic                       pwrite,
    input wire logic [7:0]                 paddr,
    input wire logic [31:0]                pwdata,
    input wire logic                       ring_switch,
    input wire logic                       test_select_n,
    input wire logic                       ptr_valid,
    input wire logic                       format_select_n,
    input wire logic                       op_select_write_n,
    input wire logic                       motion,
    input wire logic                       reel_servo_enable_n,
    input wire logic                       file_protect,
    input wire logic                       lockout_feedback_n,
    input wire logic                       write_lockout_hold,
    input wire logic                       write_power,
    input wire logic                       test_select,
    input wire logic                       wr_char_valid,
    input wire logic [twm_pkg::CHAR_W-1:0] track_amplitude_error
);
    import twm_pkg::*;
    // ------------------------------------------------------------
    // Decoded control writes
    // ------------------------------------------------------------
    logic ctrl_wr;
    logic wr_ok;
    logic rd_ok;
    assign ctrl_wr = psel && penable && pwrite && paddr == TWM_CTRL_OFS;
    assign wr_ok = ctrl_wr && (&pwdata[3:0]) && pwdata[5];
    assign rd_ok = ctrl_wr && pwdata[4] && pwdata[5] && !wr_ok;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_format_pick:
        assert property (ctrl_wr |=> format_select_n == $past(pwdata[7]))
        else $error("format select wrong");
    a_write_enter:
        assert property (wr_ok |-> ##2 !op_select_write_n && motion)
        else $error("write mode not entered");
    a_write_cause:
        assert property ($fell(op_select_write_n) |-> $past(wr_ok, 2))
        else $error("write mode without its conditions");
    a_read_enter:
        assert property (rd_ok |-> ##2 op_select_write_n && motion)
        else $error("read mode not entered");
    a_servo_load:
        assert property (ctrl_wr |=> reel_servo_enable_n == !$past(pwdata[6]))
        else $error("servo enable wrong");
    a_protect_eq:
        assert property (file_protect == lockout_feedback_n &&
            file_protect == !(write_power && !reel_servo_enable_n))
        else $error("file protect wrong");
    a_hold_path:
        assert property (write_lockout_hold == !$past(lockout_feedback_n))
        else $error("lockout hold wrong");
    a_no_ring:
        assert property (!ring_switch [*3] |-> !write_power)
        else $error("write power without ring");
    a_strobe_gate:
        assert property (wr_char_valid |->
            $past(!op_select_write_n && !file_protect))
        else $error("character taken while not writable");
    a_test_inv:
        assert property (test_select == !$past(test_select_n, 2))
        else $error("test select not inverted");
    a_amp_clear:
        assert property ($fell(op_select_write_n) && !ptr_valid ##1
            !ptr_valid |=> track_amplitude_error == 9'h000)
        else $error("error flags not cleared");
endmodule
bind twm_mode_ctrl twm_mode_ctrl_sva u_sva (.*);

// file: verification/twm_host_model.sv
// Host controller model: strobed write characters and test inputs.
// Assumes pclk from the bench; pins move just after rising edges.
`timescale 1ns/100ps
module twm_host_model (
    input  wire logic  pclk,
    output logic       host_write_strobe,
    output logic       host_write_parity,
    output logic [7:0] host_write_bit,
    output logic       test_select_n,
    output logic       test_strobe_n
);
    initial begin
        host_write_strobe = 1'b0;
        {host_write_parity, host_write_bit} = 9'h000;
        test_select_n = 1'b1;
        test_strobe_n = 1'b1;
    end
    // Data held well past the synchroniser, then scrambled
    task automatic send(input logic [8:0] c);
        {host_write_parity, host_write_bit} <= c;
        test_select_n <= !test_select_n;
        @(posedge pclk);
        host_write_strobe <= 1'b1;
        test_strobe_n <= 1'b0;
        repeat (6) @(posedge pclk);
        host_write_strobe <= 1'b0;
        test_strobe_n <= 1'b1;
        repeat (4) @(posedge pclk);
        {host_write_parity, host_write_bit} <= ~c;
        @(posedge pclk);
    endtask
endmodule

// file: verification/tb_top.sv
// Self-checking bench for twm_mode_ctrl driven over APB and host pins.
// Assumes the checker binds itself; results are matched from queues.
`timescale 1ns/100ps
module tb_top;
    import twm_pkg::*;
    logic              pclk, presetn, psel, penable, pwrite, pready;
    logic [7:0]        paddr, host_write_bit;
    logic [31:0]       pwdata, prdata;
    logic              pslverr, ring_switch, host_write_strobe, motion;
    logic              host_write_parity, test_select_n, test_strobe_n;
    logic              ptr_valid, format_select_n, op_select_write_n;
    logic              reel_servo_enable_n, file_protect, write_power;
    logic              lockout_feedback_n, write_lockout_hold;
    logic              test_select, test_strobe, wr_char_valid;
    logic [CHAR_W-1:0] raw_pointer_bit, wr_char, track_amplitude_error;
    logic [32:0]       rd_q[$];
    logic [8:0]        ch_q[$], last_c;
    int                n_mismatch, check_count, seed;
    int                miss[5] = '{0, 1, 2, 3, 5};

    twm_mode_ctrl u_dut (.*);
    twm_host_model u_host (.*);

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // ------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------
    task automatic chk(string nm, logic [32:0] e, logic [32:0] g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(logic [7:0] a, logic [32:0] e);
        rd_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic ctl(logic [31:0] d);
        apb(1'b1, TWM_CTRL_OFS, d);
        repeat (2) @(posedge pclk);
    endtask
    task automatic ptr(logic [8:0] v);
        ptr_valid <= 1'b1;
        raw_pointer_bit <= v;
        @(posedge pclk);
        ptr_valid <= 1'b0;
        raw_pointer_bit <= ~v;
        @(posedge pclk);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Oldest note is matched against each result as it shows
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite)
            chk("read", rd_q.size() ? rd_q.pop_front() : 'x,
                {pslverr, prdata});
        if (wr_char_valid === 1'b1)
            chk("char", ch_q.size() ? ch_q.pop_front() : 'x,
                {24'h0, wr_char});
    end
    initial begin
        repeat (5000) @(posedge pclk);
        n_mismatch++;
        end_of_test();
    end
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        seed = 65892;
        presetn = 1'b0;
        {psel, penable, pwrite, ptr_valid, ring_switch} = 5'h00;
        {paddr, pwdata, raw_pointer_bit} = 49'h0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(TWM_CTRL_OFS, 33'h0);
        rd(TWM_STATUS_OFS, 33'h26);
        rd(8'h10, 33'h1_0000_0000);
        $display("test reset done");
        ring_switch <= 1'b1;
        repeat (3) @(posedge pclk);
        ctl(32'hef);
        rd(TWM_STATUS_OFS, 33'h59);
        repeat (4) begin
            last_c = 9'($random(seed));
            ch_q.push_back(last_c);
            u_host.send(last_c);
        end
        rd(TWM_WDATA_OFS, {24'h0, last_c});
        ptr(last_c ^ 9'h001);
        ptr(last_c ^ 9'h100);
        rd(TWM_AMPERR_OFS, 33'h101);
        ctl(32'h00);
        ctl(32'hef);
        rd(TWM_AMPERR_OFS, 33'h0);
        $display("test write done");
        foreach (miss[i]) begin
            ctl(32'h6f & ~(32'h1 << miss[i]));
            rd(TWM_STATUS_OFS, 33'h1a);
            u_host.send(9'h0f0);
        end
        ctl(32'h70);
        rd(TWM_STATUS_OFS, 33'h1b);
        u_host.send(9'h155);
        $display("test gating done");
        ring_switch <= 1'b0;
        repeat (3) @(posedge pclk);
        ctl(32'hef);
        rd(TWM_STATUS_OFS, 33'h45);
        u_host.send(9'h1a5);
        apb(1'b1, TWM_WDATA_OFS, 32'h0aa);
        rd(TWM_WDATA_OFS, {24'h0, last_c});
        repeat (4) @(posedge pclk);
        chk("queue", 33'h0, 33'(ch_q.size()));
        $display("test no ring done");
        end_of_test();
    end
endmodule
